// file: src/rcf_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module rcf_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             clk_en,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic             push;
    logic             pop;

    // Full and empty from extended pointers
    assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid = wr_q != rd_q;
    assign push      = in_valid && in_ready && clk_en;
    assign pop       = out_valid && out_ready && clk_en;
    assign out_data  = mem[rd_q[AW-1:0]];

    // Storage has no reset; pointers guard it
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    // Pointer update
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// file: src/rcf_framer.sv
// Radar sample framer: builds CSI-2 frames of raw 12-bit I/Q samples
// Overview of operation
// - Frame opens with frame-start short packet
// - Frame closes with frame-end short packet
// - Line-start short packet before each line
// - Line-end short packet after each line
// - Up to four data lanes supported
// - Lane rate selectable 150 to 600 Mbps
// - Payload spread over the data lanes
// - Fewer lanes carry all channels multiplexed
// - Link is device-to-host, data only
// - Payload holds profile, chirp number, samples
// - Chirp-quality words switchable on or off
// - Each channel gives I and Q
// - Complex samples are 12-bit words
// - Four header words, one per channel
// - Samples interleaved channel 0..3, I then Q
// - At most 1023 samples per chirp
// - 64 quality bits in 12-bit slices, low first
// - Clock lane runs continuously once enabled
`timescale 1ns/1ps
`default_nettype none
module rcf_framer #(
    parameter int          LANES_MAX = rcf_pkg::MAX_LANES,
    parameter int          FIFO_D    = rcf_pkg::FIFO_DEPTH,
    parameter logic [1:0]  VC_ID     = 2'h0
) (
    // Core clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire logic                   clk_en,
    // Configuration
    input  wire logic                   link_enable,
    input  wire logic [2:0]             lane_count,
    input  wire logic                   quality_enable,
    input  wire logic [9:0]             rate_mbps_div,
    // Chirp descriptor and sample stream
    input  wire rcf_pkg::rcf_chirp_t    chirp_info,
    input  wire logic                   chirp_start,
    input  wire logic                   frame_last,
    input  wire rcf_pkg::rcf_sample_t   sample_in,
    input  wire logic                   sample_valid,
    output logic                        sample_ready,
    output logic                        busy,
    // Link side, on the lane byte clock
    input  wire logic                   link_clk,
    input  wire logic                   link_rst_b,
    output logic [LANES_MAX-1:0][7:0]   lane_data,
    output logic [LANES_MAX-1:0]        lane_hs_en,
    output logic                        clk_lane_hs
);
    ////////////////////////////////////////////////////////////////////////
    // Packet builder
    typedef enum logic [3:0] {
        S_IDLE, S_FS, S_LS, S_LHDR, S_HDR, S_SMP, S_CQ, S_CRC0, S_CRC1,
        S_LE, S_FE, S_SHORT
    } rcf_state_t;

    rcf_state_t         st_q;
    rcf_state_t         ret_q;
    logic [2:0]         sub_q;       // byte index in current unit
    logic [2:0]         ch_q;        // channel or word index
    logic [9:0]         smp_q;       // sample index
    logic [9:0]         nsmp_q;
    logic [15:0]        wc_q;
    logic [15:0]        crc_q;
    logic [15:0]        fnum_q;
    logic [31:0]        sp_q;        // short packet bytes
    rcf_pkg::rcf_chirp_t info_q;
    rcf_pkg::rcf_sample_t smp_hold_q;
    logic               last_frame_q;
    logic               qual_q;
    logic               smp_fresh_q;
    logic [7:0]         byte_d;
    logic               byte_v;
    logic               byte_pay;
    logic               byte_last;
    logic               fifo_rdy;
    logic [23:0]        pair_w;
    logic [11:0]        word_a;
    logic [11:0]        word_b;

    // Short packet: identifier, two data bytes, header ECC
    function automatic logic [31:0] short_pkt(input logic [5:0] dt, input logic [15:0] d);
        logic [7:0] di;
        di = {VC_ID, dt};
        short_pkt = {ecc6({d, di}), d[15:8], d[7:0], di};
    endfunction

    // CSI-2 header ECC over 24 bits
    function automatic logic [7:0] ecc6(input logic [23:0] h);
        logic [5:0] p;
        p[0] = ^(h & 24'hf12cb7);
        p[1] = ^(h & 24'hf2555b);
        p[2] = ^(h & 24'h749a6d);
        p[3] = ^(h & 24'hb8e38e);
        p[4] = ^(h & 24'hdf03f0);
        p[5] = ^(h & 24'hefe00f);
        ecc6 = {2'b00, p};
    endfunction

    // CRC-16 byte update, reflected polynomial
    function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int k = 0; k < 8; k++) begin
            r = (r[0] ^ b[k]) ? ((r >> 1) ^ rcf_pkg::CRC_POLY_R) : (r >> 1);
        end
        crc_upd = r;
    endfunction

    // Two 12-bit words pack into three RAW12 bytes
    always_comb begin
        word_a = '0;
        word_b = '0;
        case (st_q)
            S_HDR: begin
                // chirp num, channel num, profile per channel
                word_a = {info_q.chirp_num, 2'(ch_q), info_q.profile};
                word_b = {info_q.chirp_num, 2'(ch_q + 3'h1), info_q.profile};
            end
            S_SMP: begin
                word_a = smp_hold_q.i_val[ch_q[1:0]];
                word_b = smp_hold_q.q_val[ch_q[1:0]];
            end
            S_CQ: begin
                // low slices first, top slice padded with zeros
                word_a = 12'(info_q.quality >> (12 * int'(ch_q)));
                word_b = 12'(info_q.quality >> (12 * int'(ch_q) + 12));
            end
            default: begin
                word_a = '0;
                word_b = '0;
            end
        endcase
    end
    assign pair_w = {word_b, word_a};

    // Byte produced this cycle
    always_comb begin
        byte_d    = 8'h00;
        byte_v    = 1'b0;
        byte_pay  = 1'b0;
        byte_last = 1'b0;
        case (st_q)
            S_SHORT: begin
                byte_d    = sp_q[8*sub_q[1:0] +: 8];
                byte_v    = 1'b1;
                byte_last = sub_q == 3'h3;
            end
            S_LHDR: begin
                byte_d = sp_q[8*sub_q[1:0] +: 8];
                byte_v = 1'b1;
            end
            S_HDR, S_SMP, S_CQ: begin
                byte_d   = pair_w[8*sub_q[1:0] +: 8];
                byte_v   = (st_q != S_SMP) || smp_fresh_q;
                byte_pay = byte_v;
            end
            S_CRC0: begin
                byte_d = crc_q[7:0];
                byte_v = 1'b1;
            end
            S_CRC1: begin
                byte_d    = crc_q[15:8];
                byte_v    = 1'b1;
                byte_last = 1'b1;
            end
            default: begin
                byte_v = 1'b0;
            end
        endcase
    end

    // Fetch next sample only when the current one is consumed
    assign sample_ready = (st_q == S_SMP) && (ch_q == 3'h0) && (sub_q == 3'h0)
                          && !smp_fresh_q;
    assign busy = st_q != S_IDLE;

    // Sequencer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q         <= S_IDLE;
            ret_q        <= S_IDLE;
            sub_q        <= '0;
            ch_q         <= '0;
            smp_q        <= '0;
            nsmp_q       <= '0;
            wc_q         <= '0;
            crc_q        <= rcf_pkg::CRC_SEED;
            fnum_q       <= 16'h0001;
            sp_q         <= '0;
            info_q       <= '0;
            smp_hold_q   <= '0;
            smp_fresh_q  <= 1'b0;
            last_frame_q <= 1'b0;
            qual_q       <= 1'b0;
        end else if (clk_en) begin
            if (byte_v && byte_pay && fifo_rdy) begin
                crc_q <= crc_upd(crc_q, byte_d);
            end
            if (sample_ready && sample_valid) begin
                smp_hold_q  <= sample_in;
                smp_fresh_q <= 1'b1;
            end
            case (st_q)
                S_IDLE: begin
                    if (chirp_start && link_enable) begin
                        info_q       <= chirp_info;
                        last_frame_q <= frame_last;
                        qual_q       <= quality_enable;
                        nsmp_q <= (chirp_info.num_samples > 10'(rcf_pkg::MAX_SAMPLES))
                                  ? 10'(rcf_pkg::MAX_SAMPLES) : chirp_info.num_samples;
                        st_q <= S_FS;
                    end
                end
                S_FS: begin
                    sp_q  <= short_pkt(rcf_pkg::DT_FS, fnum_q);
                    ret_q <= S_LS;
                    sub_q <= '0;
                    st_q  <= S_SHORT;
                end
                S_LS: begin
                    sp_q  <= short_pkt(rcf_pkg::DT_LS, 16'h0001);
                    ret_q <= S_LHDR;
                    wc_q  <= 16'(({6'h00, nsmp_q} * 16'h000c)
                             + (qual_q ? 16'h0009 : 16'h0000) + 16'h0006);
                    sub_q <= '0;
                    st_q  <= S_SHORT;
                end
                S_SHORT: begin
                    if (fifo_rdy) begin
                        sub_q <= sub_q + 3'h1;
                        if (sub_q == 3'h3) begin
                            sub_q <= '0;
                            st_q  <= ret_q;
                            sp_q  <= short_pkt(rcf_pkg::DT_RAW12, wc_q);
                        end
                    end
                end
                S_LHDR: begin
                    if (fifo_rdy) begin
                        sub_q <= sub_q + 3'h1;
                        crc_q <= rcf_pkg::CRC_SEED;
                        if (sub_q == 3'h3) begin
                            sub_q <= '0;
                            ch_q  <= '0;
                            st_q  <= S_HDR;
                        end
                    end
                end
                S_HDR: begin
                    if (fifo_rdy) begin
                        sub_q <= sub_q + 3'h1;
                        if (sub_q == 3'h2) begin
                            sub_q <= '0;
                            ch_q  <= ch_q + 3'h2;
                            if (ch_q == 3'h2) begin
                                ch_q  <= '0;
                                smp_q <= '0;
                                st_q  <= (nsmp_q != 10'h000) ? S_SMP : (qual_q ? S_CQ : S_CRC0);
                            end
                        end
                    end
                end
                S_SMP: begin
                    if (smp_fresh_q && fifo_rdy) begin
                        sub_q <= sub_q + 3'h1;
                        if (sub_q == 3'h2) begin
                            sub_q <= '0;
                            ch_q  <= ch_q + 3'h1;
                            if (ch_q == 3'h3) begin
                                ch_q        <= '0;
                                smp_fresh_q <= 1'b0;
                                smp_q       <= smp_q + 10'h001;
                                if (smp_q + 10'h001 == nsmp_q) begin
                                    st_q <= qual_q ? S_CQ : S_CRC0;
                                end
                            end
                        end
                    end
                end
                S_CQ: begin
                    if (fifo_rdy) begin
                        sub_q <= sub_q + 3'h1;
                        if (sub_q == 3'h2) begin
                            sub_q <= '0;
                            ch_q  <= ch_q + 3'h2;
                            if (ch_q == 3'h4) begin
                                ch_q <= '0;
                                st_q <= S_CRC0;
                            end
                        end
                    end
                end
                S_CRC0: begin
                    if (fifo_rdy) begin
                        st_q <= S_CRC1;
                    end
                end
                S_CRC1: begin
                    if (fifo_rdy) begin
                        st_q <= S_LE;
                    end
                end
                S_LE: begin
                    sp_q  <= short_pkt(rcf_pkg::DT_LE, 16'h0001);
                    ret_q <= last_frame_q ? S_FE : S_IDLE;
                    sub_q <= '0;
                    st_q  <= S_SHORT;
                end
                S_FE: begin
                    sp_q   <= short_pkt(rcf_pkg::DT_FE, fnum_q);
                    fnum_q <= fnum_q + 16'h0001;
                    ret_q  <= S_IDLE;
                    sub_q  <= '0;
                    st_q   <= S_SHORT;
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte buffer between builder and lane crossing
    logic [8:0] fo_data;
    logic       fo_valid;
    logic       fo_ready;

    rcf_fifo #(
        .WIDTH (9),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .clk       (clk),
        .rst_b     (rst_b),
        .clk_en    (clk_en),
        .in_valid  (byte_v),
        .in_ready  (fifo_rdy),
        .in_data   ({byte_d, byte_last}),
        .out_valid (fo_valid),
        .out_ready (fo_ready),
        .out_data  (fo_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Handshake crossing into the link domain, one byte per exchange
    logic       req_q;
    logic [7:0] xdata_q;
    logic       ack_s1_q;
    logic       ack_s2_q;
    logic       ack_l_q;
    logic       req_s1_q;
    logic       req_s2_q;
    logic [2:0] lanes_s1_q;
    logic [2:0] lanes_s2_q;
    logic       en_s1_q;
    logic       en_s2_q;

    // Core side launches a byte when the previous one is acknowledged
    assign fo_ready = fo_valid && (req_q == ack_s2_q);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            req_q    <= 1'b0;
            xdata_q  <= '0;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else if (clk_en) begin
            ack_s1_q <= ack_l_q;
            ack_s2_q <= ack_s1_q;
            if (fo_ready) begin
                xdata_q <= fo_data[8:1];
                req_q   <= ~req_q;
            end
        end
    end

    // Link side: synchronise request and configuration levels
    always_ff @(posedge link_clk or negedge link_rst_b) begin
        if (!link_rst_b) begin
            req_s1_q   <= 1'b0;
            req_s2_q   <= 1'b0;
            ack_l_q    <= 1'b0;
            lanes_s1_q <= '0;
            lanes_s2_q <= '0;
            en_s1_q    <= 1'b0;
            en_s2_q    <= 1'b0;
        end else begin
            req_s1_q   <= req_q;
            req_s2_q   <= req_s1_q;
            ack_l_q    <= req_s2_q; // Also the last request served
            lanes_s1_q <= lane_count;
            lanes_s2_q <= lanes_s1_q;
            en_s1_q    <= link_enable;
            en_s2_q    <= en_s1_q;
        end
    end

    // Bytes distributed round-robin over active lanes; link rate set by the
    // PHY clock chosen from rate_mbps_div, within 150..600 Mbps per lane
    logic [1:0] lane_ptr_q;
    logic [1:0] lane_top;
    assign lane_top = (lanes_s2_q == 3'h0) ? 2'h0 : 2'(lanes_s2_q - 3'h1);

    always_ff @(posedge link_clk or negedge link_rst_b) begin
        if (!link_rst_b) begin
            lane_ptr_q  <= '0;
            lane_data   <= '0;
            lane_hs_en  <= '0;
            clk_lane_hs <= 1'b0;
        end else begin
            clk_lane_hs <= en_s2_q; // stays HS while enabled
            lane_hs_en  <= '0;
            if (req_s2_q != ack_l_q) begin
                lane_data[lane_ptr_q]  <= xdata_q; // transmit only
                lane_hs_en[lane_ptr_q] <= 1'b1;
                lane_ptr_q <= (lane_ptr_q >= lane_top) ? 2'h0 : lane_ptr_q + 2'h1;
            end
        end
    end
    // rate_mbps_div only selects the external PHY clock
    logic unused_rate;
    assign unused_rate = ^rate_mbps_div;
endmodule
`default_nettype wire

// file: src/rcf_pkg.sv
// Package for the radar sample framer: constants and carrier types
package rcf_pkg;
    // CSI-2 data types and conventions
    localparam logic [5:0] DT_FS       = 6'h00;
    localparam logic [5:0] DT_FE       = 6'h01;
    localparam logic [5:0] DT_LS       = 6'h02;
    localparam logic [5:0] DT_LE       = 6'h03;
    localparam logic [5:0] DT_RAW12    = 6'h2c;
    localparam logic [15:0] CRC_SEED   = 16'hffff;
    localparam logic [15:0] CRC_POLY_R = 16'h8408;
    // Payload geometry
    localparam int NUM_CH        = 4;
    localparam int HDR_WORDS     = 4;
    localparam int CQ_WORDS      = 6;
    localparam int MAX_SAMPLES   = 1023;
    localparam int SAMPLE_W      = 12;
    localparam int CQ_BITS       = 64;
    localparam int HDR_CHIRP_LSB = 6;
    localparam int HDR_CH_LSB    = 4;
    // Lane rate selection range in Mbps
    localparam int RATE_MIN_MBPS = 150;
    localparam int RATE_MAX_MBPS = 600;
    localparam int MAX_LANES     = 4;
    localparam int FIFO_DEPTH    = 8;
    localparam int BUFFER_WORDS  = MAX_SAMPLES * NUM_CH * 2;

    // One sampling instant across all channels
    typedef struct packed {
        logic [NUM_CH-1:0][SAMPLE_W-1:0] i_val;
        logic [NUM_CH-1:0][SAMPLE_W-1:0] q_val;
    } rcf_sample_t;

    // Per-chirp descriptor
    typedef struct packed {
        logic [9:0]        num_samples;
        logic [5:0]        chirp_num;
        logic [3:0]        profile;
        logic [CQ_BITS-1:0] quality;
    } rcf_chirp_t;

    // One byte to the lane distributor
    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } rcf_byte_t;
endpackage

// file: test/rcf_framer_assertions.sv
// Port checks for the radar sample framer
`timescale 1ns/1ps
`default_nettype none
module rcf_framer_assertions #(
    parameter int LANES_MAX = 4
) (
    // Core domain
    input wire logic                 clk,
    input wire logic                 rst_b,
    input wire logic                 clk_en,
    input wire logic                 link_enable,
    input wire logic [2:0]           lane_count,
    input wire logic                 chirp_start,
    input wire logic                 sample_ready,
    input wire logic                 busy,
    // Link domain
    input wire logic                 link_clk,
    input wire logic                 link_rst_b,
    input wire logic [LANES_MAX-1:0] lane_hs_en,
    input wire logic                 clk_lane_hs
);
////////////////////////////////////////////////////////////////////////////////
    // Chirp acceptance; busy must hold for at least four cycles once it rises
    AST_START_BUSY: assert property (@(posedge clk) disable iff (!rst_b)
        chirp_start && !busy && link_enable && clk_en |=> busy) else $error("start not taken");
    AST_BUSY_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(busy) |-> busy [*4]) else $error("busy too short");
    AST_READY_BUSY: assert property (@(posedge clk) disable iff (!rst_b)
        sample_ready |-> busy) else $error("ready while idle");
////////////////////////////////////////////////////////////////////////////////
    // Lane use: at most one lane strobe per cycle, no strobe beyond one or two active lanes, clock lane running
    AST_ONE_STROBE: assert property (@(posedge link_clk) disable iff (!link_rst_b)
        $onehot0(lane_hs_en)) else $error("two lane strobes");
    AST_ONE_LANE: assert property (@(posedge link_clk) disable iff (!link_rst_b)
        lane_count < 3'h2 |-> lane_hs_en[LANES_MAX-1:1] == '0) else $error("lane beyond one");
    AST_TWO_LANES: assert property (@(posedge link_clk) disable iff (!link_rst_b)
        lane_count == 3'h2 |-> lane_hs_en[LANES_MAX-1:2] == '0) else $error("lane beyond two");
    AST_HS_CLOCK: assert property (@(posedge link_clk) disable iff (!link_rst_b)
        |lane_hs_en |-> clk_lane_hs) else $error("data without clock lane");
    AST_CLK_ON: assert property (@(posedge link_clk) disable iff (!link_rst_b)
        link_enable [*6] |-> clk_lane_hs) else $error("clock lane idle");
endmodule
`default_nettype wire

// file: test/rcf_host_model.sv
// Host receiver model: gathers lane bytes in arrival order
`timescale 1ns/1ps
`default_nettype none
module rcf_host_model (
    // Link side from the framer
    input wire logic            link_clk,
    input wire logic            link_rst_b,
    input wire logic [3:0][7:0] lane_data,
    input wire logic [3:0]      lane_hs_en,
    input wire logic            clk_lane_hs
);
    logic [7:0] rx_q[$];
////////////////////////////////////////////////////////////////////////////////
    // A byte strobed while the clock lane is idle is lost
    always @(posedge link_clk) begin
        for (int i = 0; i < 4; i++) begin
            if (link_rst_b && lane_hs_en[i] && clk_lane_hs) begin
                rx_q.push_back(lane_data[i]);
            end
        end
    end
endmodule
`default_nettype wire

// file: test/tb.sv
// Testbench for the radar sample framer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module tb;
    // Stimulus, outputs and bookkeeping
    logic clk = 1'b0, link_clk = 1'b0, rst_b = 1'b0, link_rst_b = 1'b0;
    logic clk_en = 1'b1, link_enable = 1'b0, quality_enable = 1'b0;
    logic chirp_start = 1'b0, frame_last = 1'b0, sample_valid = 1'b0;
    logic [2:0] lane_count = 3'h0;
    logic [9:0] rate_mbps_div = 10'h096;
    rcf_pkg::rcf_chirp_t chirp_info = '0;
    rcf_pkg::rcf_sample_t sample_in = '0;
    logic sample_ready, busy, clk_lane_hs;
    logic [3:0] lane_hs_en;
    logic [3:0][7:0] lane_data;
    int failures = 0, checks_done = 0;
    logic [7:0] exp_q[$];
////////////////////////////////////////////////////////////////////////////////
    rcf_framer rcf_framer_inst (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
        .link_enable(link_enable), .lane_count(lane_count), .quality_enable(quality_enable),
        .rate_mbps_div(rate_mbps_div), .chirp_info(chirp_info), .chirp_start(chirp_start),
        .frame_last(frame_last), .sample_in(sample_in), .sample_valid(sample_valid),
        .sample_ready(sample_ready), .busy(busy), .link_clk(link_clk), .link_rst_b(link_rst_b),
        .lane_data(lane_data), .lane_hs_en(lane_hs_en), .clk_lane_hs(clk_lane_hs));
    rcf_host_model rcf_host_model_inst (.link_clk(link_clk), .link_rst_b(link_rst_b),
        .lane_data(lane_data), .lane_hs_en(lane_hs_en), .clk_lane_hs(clk_lane_hs));
////////////////////////////////////////////////////////////////////////////////
    // Core clock, and a link clock whose edges miss its rising edges
    always #5 clk = ~clk;
    always #80 link_clk = ~link_clk;
    // Sample value with bit 11 set on I so a narrowed field shows up
    function automatic logic [11:0] smp(input int s, input int c, input bit q);
        return q ? 12'(12'h0f0 + s * 5 + c) : 12'(12'h800 | (s << 3) | c);
    endfunction
    // Two 12-bit words give three bytes, low byte first
    task automatic put_pair(input logic [11:0] a, input logic [11:0] b);
        exp_q.push_back(a[7:0]);
        exp_q.push_back({b[3:0], a[11:8]});
        exp_q.push_back(b[11:4]);
    endtask
    task automatic give_verdict;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // One chirp: send, wait for the link to drain, then judge the byte stream
    task automatic run_chirp(input string nm, input logic [2:0] lanes, input logic qual,
                             input logic last, input int ns, input logic poke);
        rcf_pkg::rcf_chirp_t ci;
        rcf_pkg::rcf_sample_t sm;
        logic [15:0] crc;
        logic [7:0] got[$];
        int wc, total;
        ci = '{num_samples: 10'(ns), chirp_num: 6'h2d, profile: 4'h9,
               quality: 64'hfedc_ba98_7654_3210};
        exp_q.delete();
        rcf_host_model_inst.rx_q.delete();
        for (int c = 0; c < 4; c += 2) put_pair({ci.chirp_num, 2'(c), ci.profile},
                                                {ci.chirp_num, 2'(c + 1), ci.profile});
        for (int s = 0; s < ns; s++)
            for (int c = 0; c < 4; c++) put_pair(smp(s, c, 0), smp(s, c, 1));
        if (qual) begin
            for (int k = 0; k < 48; k += 24) put_pair(ci.quality[k +: 12], ci.quality[k + 12 +: 12]);
            put_pair(ci.quality[59:48], {8'h00, ci.quality[63:60]});
        end
        wc = exp_q.size();
        crc = rcf_pkg::CRC_SEED;
        foreach (exp_q[k])
            for (int b = 0; b < 8; b++)
                crc = (crc[0] ^ exp_q[k][b]) ? (crc >> 1) ^ rcf_pkg::CRC_POLY_R : crc >> 1;
        total = 18 + wc + (last ? 4 : 0);
        @(posedge clk);
        lane_count <= lanes;
        quality_enable <= qual;
        frame_last <= last;
        chirp_info <= ci;
        chirp_start <= 1'b1;
        @(posedge clk);
        chirp_start <= 1'b0;
        for (int s = 0; s < ns; s++) begin
            for (int c = 0; c < 4; c++) sm.i_val[c] = smp(s, c, 0);
            for (int c = 0; c < 4; c++) sm.q_val[c] = smp(s, c, 1);
            sample_valid <= 1'b1;
            sample_in <= sm;
            do @(posedge clk); while (sample_ready !== 1'b1);
        end
        // A start while busy must be ignored
        sample_valid <= 1'b0;
        chirp_start <= poke;
        @(posedge clk);
        chirp_start <= 1'b0;
        while (busy !== 1'b0) @(posedge clk);
        while (rcf_host_model_inst.rx_q.size() < total) @(posedge link_clk);
        repeat (40) @(posedge link_clk);
        got = rcf_host_model_inst.rx_q;
        `CHK("byte count", total, got.size())
        `CHK("frame start", {2'h0, rcf_pkg::DT_FS}, got[0])
        `CHK("line start", {2'h0, rcf_pkg::DT_LS}, got[4])
        `CHK("long id", {2'h0, rcf_pkg::DT_RAW12}, got[8])
        `CHK("word count", 16'(wc), {got[10], got[9]})
        for (int k = 0; k < wc; k++) `CHK("payload", exp_q[k], got[12 + k])
        `CHK("checksum", crc, {got[13 + wc], got[12 + wc]})
        `CHK("line end", {2'h0, rcf_pkg::DT_LE}, got[14 + wc])
        if (last) `CHK("frame end", {2'h0, rcf_pkg::DT_FE}, got[18 + wc])
        $display("test %s done", nm);
    endtask
////////////////////////////////////////////////////////////////////////////////
    // Main sequence; the link reset spans several link edges
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        link_enable <= 1'b1;
        repeat (3) @(posedge link_clk);
        link_rst_b <= 1'b1;
        repeat (8) @(posedge link_clk);
        run_chirp("four lanes", 3'h4, 1'b0, 1'b1, 2, 1'b0);
        run_chirp("one lane quality", 3'h0, 1'b1, 1'b0, 1, 1'b0);
        run_chirp("two lanes late start", 3'h2, 1'b1, 1'b1, 3, 1'b1);
        give_verdict;
    end
    // Watchdog at about five times the expected run
    initial begin
        #500_000;
        failures++;
        give_verdict;
    end
endmodule
bind rcf_framer rcf_framer_assertions #(.LANES_MAX(LANES_MAX)) rcf_framer_assertions_inst (
    .clk(clk), .rst_b(rst_b), .clk_en(clk_en), .link_enable(link_enable),
    .lane_count(lane_count), .chirp_start(chirp_start), .sample_ready(sample_ready),
    .busy(busy), .link_clk(link_clk), .link_rst_b(link_rst_b), .lane_hs_en(lane_hs_en),
    .clk_lane_hs(clk_lane_hs));
`default_nettype wire
